/* File: reloadable_interval_timer.sv */
// reloadable 16-bit interval timer with a processor bus port
`timescale 1ns/1ps
module reloadable_interval_timer
  import timer_pkg::*;
(
  input  wire logic              clk,               // fast input clock, 25 MHz
  input  wire logic              sys_rst,           // synchronous reset, active high
  input  wire logic              chip_select_n,     // chip select, active low
  input  wire logic              read_n,            // read strobe, active low
  input  wire logic              write_n,           // write strobe, active low
  input  wire logic              register_select_n, // low reload_value, high counter
  input  wire logic [DATA_W-1:0] data_bus_lines_i,  // data lines from the processor
  output logic      [DATA_W-1:0] data_bus_lines_o,  // data lines to the processor
  output logic                   data_bus_lines_oe, // high while driving the data lines
  output logic                   zero_toggle        // divided clock / interrupt level
);

  ////////////////////////////////////////////////////////////////////////////
  // strobe synchronisation

  logic [3:0] sync_w;
  logic       cs_s_n;
  logic       rd_s_n;
  logic       wr_s_n;
  logic       sel_s;

  // data lines are not synchronised; the processor holds them through the write
  strobe_sync #(
    .WIDTH    (4)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in ({chip_select_n, read_n, write_n, register_select_n}),
    .sync_out (sync_w)
  );

  assign cs_s_n = sync_w[3];
  assign rd_s_n = sync_w[2];
  assign wr_s_n = sync_w[1];
  assign sel_s  = sync_w[0];

  ////////////////////////////////////////////////////////////////////////////
  // bus cycle decoding

  logic       rd_cyc;
  logic       wr_cyc;
  bus_state_e bus_q;
  bus_state_e bus_d;
  logic       wr_start;
  logic       rd_start;

  assign rd_cyc = !cs_s_n && !rd_s_n && wr_s_n;
  assign wr_cyc = !cs_s_n && rd_s_n && !wr_s_n;

  always_comb
  begin
    case (bus_q)
      BUS_IDLE:  bus_d = rd_cyc ? BUS_READ : (wr_cyc ? BUS_WRITE : BUS_IDLE);
      BUS_READ:  bus_d = rd_cyc ? BUS_READ : BUS_IDLE;
      BUS_WRITE: bus_d = wr_cyc ? BUS_WRITE : BUS_IDLE;
      default:   bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      bus_q <= BUS_IDLE;
    else
      bus_q <= bus_d;
  end

  // each cycle acts once, on its first synchronised cycle; a strobe shorter
  // than one clock may be missed, since it must survive the synchroniser
  assign wr_start = (bus_q == BUS_IDLE) && wr_cyc;
  assign rd_start = (bus_q == BUS_IDLE) && rd_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  logic wr_reload;
  logic wr_stop;
  logic rd_enable;

  assign wr_reload = wr_start && (sel_s == SEL_RELOAD);
  assign wr_stop   = wr_start && (sel_s == SEL_COUNTER);
  assign rd_enable = rd_start && (sel_s == SEL_COUNTER);

  ////////////////////////////////////////////////////////////////////////////
  // reload register

  logic [DATA_W-1:0] reload_value_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      reload_value_q <= RELOAD_RESET;
    else if (wr_reload)
      reload_value_q <= data_bus_lines_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // down counter

  logic [DATA_W-1:0] live_down_count_q;
  logic              run_q;
  logic              loaded_q;
  logic              at_zero;

  // counting never pauses for the bus; a reader gets a captured copy
  // of the count, so a long read cannot slow the divided clock
  assign at_zero = (live_down_count_q == COUNT_ZERO);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      run_q <= 1'b0;
    else if (wr_stop)
      run_q <= 1'b0;
    else if (rd_enable)
      run_q <= 1'b1;
  end

  // loaded_q marks that the counter holds a value taken from reload_value;
  // the first enabled cycle only loads and does not count as a zero crossing
  always_ff @(posedge clk)
  begin
    if (sys_rst || wr_stop)
    begin
      live_down_count_q <= LIVE_RESET;
      loaded_q          <= 1'b0;
    end
    else if (run_q)
    begin
      if (!loaded_q)
      begin
        live_down_count_q <= reload_value_q;
        loaded_q          <= 1'b1;
      end
      else if (at_zero)
        live_down_count_q <= reload_value_q;
      else
        live_down_count_q <= live_down_count_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // zero toggle output

  logic zero_hit;
  logic zero_toggle_q;

  // a stopped one-shot sits at zero; only count down into zero toggles again
  logic was_zero_q;
  assign zero_hit = run_q && loaded_q && at_zero && !was_zero_q;

  always_ff @(posedge clk)
  begin
    if (sys_rst || wr_stop)
      was_zero_q <= 1'b0;
    else if (run_q && loaded_q)
      was_zero_q <= at_zero && (reload_value_q == COUNT_ZERO);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      zero_toggle_q <= 1'b0;
    else if (wr_stop)
      zero_toggle_q <= 1'b0;
    else if (zero_hit)
      zero_toggle_q <= !zero_toggle_q;
  end

  assign zero_toggle = zero_toggle_q;

  ////////////////////////////////////////////////////////////////////////////
  // read data path

  logic [DATA_W-1:0] rd_data_q;
  logic              drive_q;

  // the live count is captured once so it cannot change under the reader
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rd_data_q <= COUNT_ZERO;
    else if (rd_start)
      rd_data_q <= (sel_s == SEL_COUNTER) ? live_down_count_q : reload_value_q;
  end

  // drive only once rd_data_q holds this cycle's capture, never stale data
  // left from a read cycle that started while a write was still closing
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      drive_q <= 1'b0;
    else
      drive_q <= rd_start || (drive_q && rd_cyc);
  end

  assign data_bus_lines_o  = rd_data_q;
  assign data_bus_lines_oe = drive_q && rd_cyc;

endmodule // reloadable_interval_timer

/* File: strobe_sync.sv */
// two-stage synchroniser for the asynchronous bus strobes
`timescale 1ns/1ps
module strobe_sync
  import timer_pkg::*;
#(
  parameter int WIDTH = 4
)(
  input  wire logic             clk,      // system clock
  input  wire logic             sys_rst,  // synchronous reset
  input  wire logic [WIDTH-1:0] async_in, // raw strobes, idle high
  output logic      [WIDTH-1:0] sync_out  // synchronised strobes
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          meta_q   <= 1'b1;
          stable_q <= 1'b1;
        end
        else
        begin
          meta_q   <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate
endmodule // strobe_sync

/* File: test_reloadable_interval_timer.sv */
// self-checking bench for the interval timer
`timescale 1ns/1ps
module test_reloadable_interval_timer
  import timer_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chip_select_n, read_n, write_n, register_select_n, data_bus_lines_oe, zero_toggle;
  logic [DATA_W-1:0] data_bus_lines_i, data_bus_lines_o, q;
  int fails = 0, n_checks = 0, cyc_n = 0, m_rl = 0, n;
  initial
  begin
    forever #20 clk = ~clk;
  end
  reloadable_interval_timer i_dut (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .chip_select_n     (chip_select_n),
    .read_n            (read_n),
    .write_n           (write_n),
    .register_select_n (register_select_n),
    .data_bus_lines_i  (data_bus_lines_i),
    .data_bus_lines_o  (data_bus_lines_o),
    .data_bus_lines_oe (data_bus_lines_oe),
    .zero_toggle       (zero_toggle)
  );
  timer_host_model i_host (
    .clk               (clk),
    .chip_select_n     (chip_select_n),
    .read_n            (read_n),
    .write_n           (write_n),
    .register_select_n (register_select_n),
    .data_bus_lines_i  (data_bus_lines_i),
    .data_bus_lines_o  (data_bus_lines_o),
    .data_bus_lines_oe (data_bus_lines_oe)
  );
  task automatic chk(input string what, input logic [15:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", what, e, s);
      fails++;
    end
  endtask
  task automatic rd(input logic s);
    i_host.cyc(1'b0, 1'b0, s, 16'h0, q);
  endtask
  task automatic wr(input logic c, s, input int d);
    i_host.cyc(c, 1'b1, s, d[15:0], q);
    if (!c && !s)
      m_rl = d;
  endtask
  // cycles to the next toggle, capped so a dead output cannot hang
  task automatic gap(input int cap);
    logic t;
    t = zero_toggle;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (zero_toggle === t && n < cap);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(23379));
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    gap(40);
    chk("idle", 16'd40, n[15:0]);
    rd(1'b0);
    chk("reload rst", RELOAD_RESET, q);
    wr(1'b0, 1'b0, 3 + $urandom % 13);
    wr(1'b1, 1'b0, 16'hffff);
    rd(1'b0);
    chk("reload", m_rl[15:0], q);
    rd(1'b1);
    chk("count", 16'h0000, q);
    repeat (2) gap(4000);
    chk("period", m_rl[15:0] + 16'h1, n[15:0]);
    rd(1'b1);
    chk("live", 16'h1, {15'h0, q <= m_rl[15:0]});
    wr(1'b0, 1'b0, 18 + $urandom % 10);
    repeat (2) gap(4000);
    chk("new period", m_rl[15:0] + 16'h1, n[15:0]);
    wr(1'b0, 1'b1, 0);
    gap(200);
    chk("stop gap", 16'd200, n[15:0]);
    chk("stopped", 16'h0, {15'h0, zero_toggle});
    rd(1'b1);
    chk("after stop", LIVE_RESET, q);
    wr(1'b0, 1'b0, 0);
    gap(100);
    chk("shot fired", 16'h1, {15'h0, n < 100});
    repeat (2) gap(100);
    chk("one shot", 16'd100, n[15:0]);
    tally_and_finish();
  end
endmodule // test_reloadable_interval_timer
bind reloadable_interval_timer timer_checker i_chk (
  .clk               (clk),
  .sys_rst           (sys_rst),
  .chip_select_n     (chip_select_n),
  .read_n            (read_n),
  .write_n           (write_n),
  .register_select_n (register_select_n),
  .data_bus_lines_o  (data_bus_lines_o),
  .data_bus_lines_oe (data_bus_lines_oe),
  .zero_toggle       (zero_toggle)
);

/* File: timer_checker_assertions.sv */
// assertions on the timer ports
`timescale 1ns/1ps
module timer_checker
  import timer_pkg::*;
(
  input wire logic              clk,               // clock
  input wire logic              sys_rst,           // reset
  input wire logic              chip_select_n,     // select
  input wire logic              read_n,            // read
  input wire logic              write_n,           // write
  input wire logic              register_select_n, // register
  input wire logic [DATA_W-1:0] data_bus_lines_o,  // data out
  input wire logic              data_bus_lines_oe, // drive
  input wire logic              zero_toggle        // toggle
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // raw command is enough: the synchronised one can only come later
  logic en_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      en_q <= 1'b0;
    else if (!chip_select_n && !read_n && register_select_n)
      en_q <= 1'b1;
  end
  a_oe_source:
    assert property (data_bus_lines_oe |-> !$past(read_n, 2) && !$past(chip_select_n, 2))
    else $error("drive outside read");
  a_oe_stable:
    assert property (data_bus_lines_oe && $past(data_bus_lines_oe) |-> $stable(data_bus_lines_o))
    else $error("read data moved");
  a_reset_quiet:
    assert property ($past(sys_rst) |-> !zero_toggle && !data_bus_lines_oe)
    else $error("not idle after reset");
  a_toggle_needs_en:
    assert property ($changed(zero_toggle) |-> en_q)
    else $error("toggle before enable");
  a_read_latency:
    assert property ($fell(read_n) && !chip_select_n && write_n |-> ##[2:3] data_bus_lines_oe)
    else $error("read not answered");
  a_stop_cmd:
    assert property ($fell(write_n) && !chip_select_n && read_n && register_select_n
      |-> ##4 !zero_toggle[*4])
    else $error("stop command ignored");
  a_oe_release:
    assert property ($rose(read_n) |-> ##2 !data_bus_lines_oe)
    else $error("drive not released");
  a_toggle_gap:
    assert property ($changed(zero_toggle) |-> ##1 $stable(zero_toggle))
    else $error("toggle too fast");
endmodule // timer_checker

/* File: timer_host_model.sv */
// processor bus master for the timer
`timescale 1ns/1ps
module timer_host_model
  import timer_pkg::*;
(
  input  wire logic              clk,               // clock
  output logic                   chip_select_n,     // select
  output logic                   read_n,            // read
  output logic                   write_n,           // write
  output logic                   register_select_n, // register
  output logic      [DATA_W-1:0] data_bus_lines_i,  // data to device
  input  wire logic [DATA_W-1:0] data_bus_lines_o,  // data from device
  input  wire logic              data_bus_lines_oe  // device drives
);
  initial
  begin
    {chip_select_n, read_n, write_n, register_select_n} = 4'hf;
    data_bus_lines_i = 16'h5a5a;
  end
  // five clocks low, four idle: the device synchronises the strobes
  task automatic cyc(input logic c, w, s, input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    #1;
    chip_select_n = c;
    register_select_n = s;
    data_bus_lines_i = d;
    if (w)
      write_n = 1'b0;
    else
      read_n = 1'b0;
    repeat (5) @(posedge clk);
    q = (data_bus_lines_oe === 1'b1) ? data_bus_lines_o : 16'hxxxx;
    #1;
    {chip_select_n, read_n, write_n} = 3'h7;
    data_bus_lines_i = ~d; // released lines must not keep the word
    repeat (4) @(posedge clk);
  endtask
endmodule // timer_host_model

/* File: timer_pkg.sv */
// constants for the reloadable interval timer
package timer_pkg;
  localparam int          DATA_W       = 16;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] LIVE_RESET   = 16'h0000;
  localparam int          SYNC_STAGES  = 2;
  localparam logic        SEL_RELOAD   = 1'b0; // register_select_n level for reload_value
  localparam logic        SEL_COUNTER  = 1'b1; // register_select_n level for live_down_count
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_READ  = 2'b01,
    BUS_WRITE = 2'b11
  } bus_state_e;
endpackage
